// file: hdl/pfs_divider.v
// Divider making a one-cycle pulse every DIV clocks that have step_in high.
// Assumes the core clock keeps running on standby power.
`timescale 1ns/100ps
module pfs_divider #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] DIV = 16'd20000
) (
  // Clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // Pulse input enable and output
  input wire step_in,
  output reg pulse_out
);
  reg [WIDTH-1:0] count;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= {WIDTH{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= 1'b0;
      if (step_in) begin
        if (count == DIV - 1'b1) begin
          count <= {WIDTH{1'b0}};
          pulse_out <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// file: hdl/pfs_supervisor.v
// Power fail supervisor: interrupt sequencing, restart timer, outage
// accumulator, mains tick and machine cycle select. Host bus is a simple
// synchronous strobe interface on the core clock; pins are synchronised.
// Operation
// - Low mains must persist 50 ms to fail; good mains 50 ms to restore.
// - A detected failure drives the non-maskable interrupt low immediately.
// - Non-maskable interrupt stays low until the reset line has gone low.
// - Reset line goes low 3 ms after the non-maskable interrupt falls.
// - Reset line stays low until 150 ms after restoration, also at startup.
// - Tick request raised once per mains cycle, between 270 and 330 degrees.
// - Tick status reads on data bit 8 at 5FFF; a write there clears it.
// - Maskable request line is shared by the tick and four serial adapters.
// - Restart timer output idles high and starts timing at interrupt fall.
// - After 1.75 s output goes low until 50 ms after reset rises.
// - If power returns before expiry output stays high and count clears.
// - Accumulator counts from interrupt fall until reset rises after restore.
// - Accumulator holds 8-bit minutes and 8-bit seconds counters.
// - Seconds count 0 to 59; at 60 they clear and minutes increment.
// - Counting stops once minutes reach 255.
// - A host write to 5000 clears minutes and seconds.
// - Reads return minutes at 5000 and seconds at 500F.
// - Strap selects 0.651 or 1.302 us machine cycle; installed means slow.
`timescale 1ns/100ps
`include "pfs_consts.vh"
module pfs_supervisor #(
  parameter QUAL_MS = `PFS_QUAL_MS,
  parameter NMI_TO_RST_MS = `PFS_NMI_TO_RST_MS,
  parameter RST_HOLD_MS = `PFS_RST_HOLD_MS,
  parameter RESTART_MS = `PFS_RESTART_MS,
  parameter TAIL_MS = `PFS_RESTART_TAIL_MS,
  parameter MS_CYCLES = `PFS_MS_CYCLES,
  parameter SEC_MS = `PFS_SEC_MS
) (
  // Clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // Mains detector and phase pins (asynchronous)
  input wire mains_low_in,
  input wire mains_phase_in,
  // Serial adapter requests (active low, asynchronous)
  input wire [3:0] serial_adapter_irq_n_in,
  // Machine cycle strap (high when installed)
  input wire cycle_strap_in,
  // Host bus
  input wire bus_sel_in,
  input wire bus_wr_in,
  input wire [15:0] bus_addr_in,
  input wire [7:0] bus_wdata_in,
  output reg [7:0] bus_rdata_out,
  // Host processor lines
  output reg nmi_n_out,
  output reg processor_reset_line_n_out,
  output wire irq_n_out,
  output reg restart_timer_out,
  output reg slow_cycle_out,
  output reg [10:0] cycle_ns_out,
  output reg power_good_out
);
  localparam ST_RUN = 2'd0;
  localparam ST_NMI = 2'd1;
  localparam ST_RST = 2'd2;
  localparam ST_HOLD = 2'd3;

  wire mains_low_s;
  wire phase_s;
  wire [3:0] ser_irq_n_s;
  wire strap_s;
  wire ms_pulse;
  wire sec_pulse;
  reg [1:0] state;
  reg [15:0] qual_ms;
  reg [15:0] seq_ms;
  reg [15:0] rt_ms;
  reg [15:0] tail_ms;
  reg rt_expired;
  reg rt_tail;
  reg counting;
  reg [7:0] minutes;
  reg [7:0] seconds;
  reg tick_flag;
  reg phase_d;
  reg rst_d;

  pfs_sync u_sync_low (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .async_in(mains_low_in), .sync_out(mains_low_s));
  pfs_sync u_sync_phase (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .async_in(mains_phase_in), .sync_out(phase_s));
  pfs_sync u_sync_strap (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .async_in(cycle_strap_in), .sync_out(strap_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ser
      // Active-low requests idle high, so their synchronisers reset high
      pfs_sync #(.INIT(1'b1)) u_sync_ser (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .async_in(serial_adapter_irq_n_in[gi]), .sync_out(ser_irq_n_s[gi]));
    end
  endgenerate

  // Millisecond and second enables
  pfs_divider #(.WIDTH(16), .DIV(MS_CYCLES[15:0])) u_ms_div (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .step_in(1'b1), .pulse_out(ms_pulse));
  pfs_divider #(.WIDTH(16), .DIV(SEC_MS[15:0])) u_sec_div (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .step_in(ms_pulse), .pulse_out(sec_pulse));

  function hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  wire wr_min = bus_sel_in && bus_wr_in && hit(bus_addr_in, `PFS_ADDR_MINUTES);
  wire wr_tick = bus_sel_in && bus_wr_in && hit(bus_addr_in, `PFS_ADDR_TICK);
  // Mains disagreeing with the present state, qualified over QUAL_MS
  wire mismatch = (state == ST_RUN) ? mains_low_s : !mains_low_s;
  wire qualified = mismatch && (qual_ms == QUAL_MS[15:0] - 16'd1) && ms_pulse;

  // Qualification counter restarts whenever mains agrees with the state
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      qual_ms <= 16'd0;
    end else if (!mismatch || qualified) begin
      qual_ms <= 16'd0;
    end else if (ms_pulse) begin
      qual_ms <= qual_ms + 16'd1;
    end
  end

  // Interrupt sequencer; reset starts held for startup
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_HOLD;
      seq_ms <= 16'd0;
      nmi_n_out <= 1'b1;
      processor_reset_line_n_out <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          power_good_out <= 1'b1;
          if (qualified) begin
            nmi_n_out <= 1'b0;
            power_good_out <= 1'b0;
            seq_ms <= 16'd0;
            state <= ST_NMI;
          end
        end
        ST_NMI: begin
          if (ms_pulse) begin
            if (seq_ms == NMI_TO_RST_MS[15:0] - 16'd1) begin
              processor_reset_line_n_out <= 1'b0;
              state <= ST_RST;
            end else begin
              seq_ms <= seq_ms + 16'd1;
            end
          end
        end
        ST_RST: begin
          nmi_n_out <= 1'b1;
          seq_ms <= 16'd0;
          if (qualified) begin
            power_good_out <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (mains_low_s) begin
            seq_ms <= 16'd0;
            power_good_out <= 1'b0;
          end else begin
            power_good_out <= 1'b1;
            if (ms_pulse) begin
              if (seq_ms == RST_HOLD_MS[15:0] - 16'd1) begin
                processor_reset_line_n_out <= 1'b1;
                state <= ST_RUN;
              end else begin
                seq_ms <= seq_ms + 16'd1;
              end
            end
          end
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  wire outage = (state == ST_NMI) || (state == ST_RST);
  wire rst_rise = processor_reset_line_n_out && !rst_d;

  // Restart timer
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rt_ms <= 16'd0;
      rt_expired <= 1'b0;
      rt_tail <= 1'b0;
      tail_ms <= 16'd0;
      restart_timer_out <= 1'b1;
      rst_d <= 1'b0;
    end else begin
      rst_d <= processor_reset_line_n_out;
      if (!rt_expired) begin
        if (!outage) begin
          rt_ms <= 16'd0;
        end else if (ms_pulse) begin
          if (rt_ms == RESTART_MS[15:0] - 16'd1) begin
            rt_expired <= 1'b1;
            restart_timer_out <= 1'b0;
          end else begin
            rt_ms <= rt_ms + 16'd1;
          end
        end
      end else if (rst_rise) begin
        rt_tail <= 1'b1;
        tail_ms <= 16'd0;
      end else if (rt_tail && ms_pulse) begin
        if (tail_ms == TAIL_MS[15:0] - 16'd1) begin
          restart_timer_out <= 1'b1;
          rt_expired <= 1'b0;
          rt_tail <= 1'b0;
          rt_ms <= 16'd0;
        end else begin
          tail_ms <= tail_ms + 16'd1;
        end
      end
    end
  end

  // Outage accumulator
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      counting <= 1'b0;
      minutes <= `PFS_RESET_ZERO;
      seconds <= `PFS_RESET_ZERO;
    end else begin
      if (state == ST_RUN && qualified) begin
        counting <= 1'b1;
      end else if (rst_rise) begin
        counting <= 1'b0;
      end
      if (wr_min) begin
        minutes <= `PFS_RESET_ZERO;
        seconds <= `PFS_RESET_ZERO;
      end else if (counting && sec_pulse && minutes != `PFS_MIN_LAST) begin
        if (seconds == `PFS_SEC_LAST) begin
          seconds <= `PFS_RESET_ZERO;
          minutes <= minutes + 8'h01;
        end else begin
          seconds <= seconds + 8'h01;
        end
      end
    end
  end

  // Mains tick: phase input is high over the 270..330 degree window
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_d <= 1'b0;
      tick_flag <= 1'b0;
    end else begin
      phase_d <= phase_s;
      if (phase_s && !phase_d) begin
        tick_flag <= 1'b1;
      end else if (wr_tick) begin
        tick_flag <= 1'b0;
      end
    end
  end

  assign irq_n_out = !tick_flag && (&ser_irq_n_s);

  // Read data register; 8-bit bus, tick status on its top (eighth) bit
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_rdata_out <= 8'h00;
    end else if (bus_sel_in && !bus_wr_in) begin
      if (hit(bus_addr_in, `PFS_ADDR_MINUTES)) begin
        bus_rdata_out <= minutes;
      end else if (hit(bus_addr_in, `PFS_ADDR_SECONDS)) begin
        bus_rdata_out <= seconds;
      end else if (hit(bus_addr_in, `PFS_ADDR_TICK)) begin
        bus_rdata_out <= {tick_flag, 7'h00};
      end else begin
        bus_rdata_out <= 8'h00;
      end
    end
  end

  // Machine cycle select
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slow_cycle_out <= 1'b0;
      cycle_ns_out <= 11'h28B;
    end else begin
      slow_cycle_out <= strap_s;
      cycle_ns_out <= strap_s ? 11'h516 : 11'h28B;
    end
  end
endmodule

// file: hdl/pfs_sync.v
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is quasi-static relative to the core clock.
`timescale 1ns/100ps
module pfs_sync #(
  // Reset level, set to the idle level of the pin to avoid a false event
  parameter INIT = 1'b0
) (
  // Clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // Level
  input wire async_in,
  output reg sync_out
);
  reg stage1;
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// file: shared/pfs_consts.vh
// Constants for the power fail supervisor: bus addresses, fields, timing.
// Included by the supervisor only; holds definitions only.
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH
`define PFS_ADDR_MINUTES 16'h5000
`define PFS_ADDR_SECONDS 16'h500F
`define PFS_ADDR_TICK 16'h5FFF
`define PFS_TICK_BIT 8
`define PFS_RESET_ZERO 8'h00
`define PFS_SEC_LAST 8'h3B
`define PFS_MIN_LAST 8'hFF
`define PFS_CLK_HZ 20000000
`define PFS_QUAL_MS 50
`define PFS_NMI_TO_RST_MS 3
`define PFS_RST_HOLD_MS 150
`define PFS_RESTART_MS 1750
`define PFS_RESTART_TAIL_MS 50
`define PFS_MS_CYCLES (`PFS_CLK_HZ / 1000)
`define PFS_SEC_MS 1000
`define PFS_PHASE_START_DEG 270
`define PFS_PHASE_END_DEG 330
`define PFS_CYCLE_FAST_NS 651
`define PFS_CYCLE_SLOW_NS 1302
`define PFS_MAINS_PERIOD_CYCLES 333333
`endif

// file: verification/pfs_host_model.sv
// Host processor bus model: strobed reads and writes.
// Assumes an access is taken at the edge with select high.
`timescale 1ns/100ps
module pfs_host_model (
  // Clock
  input wire core_clk_in,
  // Bus
  output reg bus_sel_in = 1'b0,
  output reg bus_wr_in = 1'b0,
  output reg [15:0] bus_addr_in = 16'h0000,
  output reg [7:0] bus_wdata_in = 8'h00,
  input wire [7:0] bus_rdata_out
);
  task access(input w, input [15:0] a, output [7:0] d);
    begin
      @(posedge core_clk_in);
      bus_sel_in <= 1'b1;
      bus_wr_in <= w;
      bus_addr_in <= a;
      bus_wdata_in <= 8'hA5;
      @(posedge core_clk_in);
      bus_sel_in <= 1'b0;
      bus_addr_in <= ~a;
      bus_wdata_in <= 8'h5A;
      #1 d = bus_rdata_out;
    end
  endtask
endmodule

// file: verification/pfs_sup_asserts.sv
// Checker on the supervisor ports.
// Assumes MS_CYCLES of 10: one millisecond is ten clocks.
`timescale 1ns/100ps
module pfs_sup_asserts (
  // Clock and reset
  input wire core_clk_in, arst_n_in,
  // Inputs
  input wire mains_low_in, mains_phase_in, cycle_strap_in, bus_sel_in, bus_wr_in,
  input wire [3:0] serial_adapter_irq_n_in,
  input wire [15:0] bus_addr_in,
  input wire [7:0] bus_wdata_in,
  // Outputs
  input wire [7:0] bus_rdata_out,
  input wire nmi_n_out, processor_reset_line_n_out, irq_n_out,
  input wire restart_timer_out, slow_cycle_out, power_good_out,
  input wire [10:0] cycle_ns_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire rd = bus_sel_in && !bus_wr_in;
  wire mapped = bus_addr_in == 16'h5000 || bus_addr_in == 16'h500F || bus_addr_in == 16'h5FFF;
  sequence wr_min;
    bus_sel_in && bus_wr_in && bus_addr_in == 16'h5000;
  endsequence
  sequence rd_min;
    rd && bus_addr_in == 16'h5000;
  endsequence
  chk_nmi_release: assert property ($rose(nmi_n_out) |-> !processor_reset_line_n_out)
    else $error("nmi release");
  chk_nmi_cause: assert property ($fell(nmi_n_out) |-> mains_low_in)
    else $error("nmi without failure");
  chk_reset_delay: assert property ($fell(nmi_n_out) |-> ##[20:40] $fell(processor_reset_line_n_out))
    else $error("reset delay");
  chk_restart_fall: assert property ($fell(restart_timer_out) |-> !processor_reset_line_n_out)
    else $error("restart fall");
  chk_restart_tail: assert property ($rose(processor_reset_line_n_out) && !restart_timer_out
    |-> ##[480:520] $rose(restart_timer_out))
    else $error("restart tail");
  chk_unmapped_zero: assert property (rd && !mapped |=> bus_rdata_out == 8'h00)
    else $error("unmapped read");
  chk_seconds_range: assert property (rd && bus_addr_in == 16'h500F |=> bus_rdata_out <= 8'h3B)
    else $error("seconds range");
  chk_clear_minutes: assert property (wr_min ##2 rd_min |=> bus_rdata_out == 8'h00)
    else $error("minutes clear");
  chk_cycle_select: assert property (cycle_ns_out == (slow_cycle_out ? 11'h516 : 11'h28B))
    else $error("cycle select");
  chk_serial_share: assert property ((!(&serial_adapter_irq_n_in))[*4] |-> !irq_n_out)
    else $error("shared irq");
endmodule
bind pfs_supervisor pfs_sup_asserts chk (.*);

// file: verification/power_fail_supervisor_dta_test.sv
// Testbench for the power fail supervisor at ten clocks per millisecond.
// Assumes the host model carries all bus traffic.
`timescale 1ns/100ps
module power_fail_supervisor_dta_test;
  reg core_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg mains_low_in = 1'b0;
  reg mains_phase_in = 1'b0;
  reg cycle_strap_in = 1'b0;
  reg [3:0] serial_adapter_irq_n_in = 4'hF;
  wire bus_sel_in, bus_wr_in, nmi_n_out, processor_reset_line_n_out, irq_n_out;
  wire restart_timer_out, slow_cycle_out, power_good_out;
  wire [15:0] bus_addr_in;
  wire [7:0] bus_wdata_in, bus_rdata_out;
  wire [10:0] cycle_ns_out;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer t;
  reg [7:0] d;
  initial forever #25 core_clk_in = ~core_clk_in;
  pfs_supervisor #(.MS_CYCLES(10), .SEC_MS(10)) dut (.*);
  pfs_host_model host (.*);
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task wait_rst;
    begin
      t = 0;
      while (processor_reset_line_n_out !== 1'b1) begin
        tick(1);
        t = t + 1;
      end
    end
  endtask
  task test_reset;
    begin
      check(processor_reset_line_n_out, 0, "rst");
      check(restart_timer_out, 1, "restart");
      host.access(1'b0, 16'h500F, d);
      check(d, 0, "sec");
      host.access(1'b0, 16'h1234, d);
      check(d, 0, "unmapped");
      wait_rst;
      check(t > 1450 && t < 1520, 1, "hold");
      $display("test_reset done");
    end
  endtask
  task test_irq;
    integer i;
    begin
      mains_phase_in <= 1'b1;
      tick(10);
      mains_phase_in <= 1'b0;
      host.access(1'b0, 16'h5FFF, d);
      check(d[7], 1, "tick");
      check(irq_n_out, 0, "tick irq");
      host.access(1'b1, 16'h5FFF, d);
      host.access(1'b0, 16'h5FFF, d);
      check({d[7], irq_n_out}, 1, "tick clear");
      for (i = 0; i < 4; i = i + 1) begin
        tick(1);
        serial_adapter_irq_n_in <= ~(4'h1 << i);
        tick(4);
        check(irq_n_out, 0, "serial irq");
        serial_adapter_irq_n_in <= 4'hF;
      end
      cycle_strap_in <= 1'b1;
      tick(5);
      check(cycle_ns_out, 11'h516, "slow cycle");
      check(slow_cycle_out, 1, "strap");
      $display("test_irq done");
    end
  endtask
  task test_glitch;
    begin
      tick(1);
      mains_low_in <= 1'b1;
      tick(200);
      mains_low_in <= 1'b0;
      tick(600);
      check({nmi_n_out, power_good_out}, 3, "glitch");
      $display("test_glitch done");
    end
  endtask
  task test_outage(input integer low, input integer mins, input integer secs, input exp_rst);
    begin
      host.access(1'b1, 16'h5000, d);
      host.access(1'b0, 16'h5000, d);
      check(d, 0, "clear min");
      host.access(1'b0, 16'h500F, d);
      check(d, 0, "clear");
      tick(1);
      mains_low_in <= 1'b1;
      t = 0;
      while (nmi_n_out !== 1'b0) begin
        tick(1);
        t = t + 1;
      end
      check(t > 492 && t < 515, 1, "qualify");
      tick(40);
      check(processor_reset_line_n_out, 0, "rst low");
      check(nmi_n_out, 1, "nmi release");
      tick(low - t - 40);
      check(restart_timer_out, exp_rst, "restart");
      mains_low_in <= 1'b0;
      wait_rst;
      host.access(1'b0, 16'h5000, d);
      check(d, mins, "min");
      host.access(1'b0, 16'h500F, d);
      check(d >= secs - 1 && d <= secs + 1, 1, "sec");
      tick(530);
      check(restart_timer_out, 1, "restart end");
      check(power_good_out, 1, "power good");
      $display("test_outage done");
    end
  endtask
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  initial begin
    tick(16);
    arst_n_in <= 1'b1;
    test_reset;
    test_irq;
    test_glitch;
    test_outage(1000, 0, 25, 1'b1);
    test_outage(20000, 3, 35, 1'b0);
    final_report;
  end
endmodule
